// File: src/wwd_pkg.sv
// Package for the windowed watchdog: register map, fields, reset values
package wwd_pkg;

   // Register byte offsets (one aligned 32-bit word each)
   localparam logic [3:0] WWD_CTRL_OFS   = 4'h0;
   localparam logic [3:0] WWD_MODE_OFS   = 4'h4;
   localparam logic [3:0] WWD_DELTA_OFS  = 4'h8;
   localparam logic [3:0] WWD_STATUS_OFS = 4'hC;

   // Control word: reload strobe and protect key
   localparam int               WWD_CTRL_RELOAD_BIT = 0;
   localparam logic [15:0]      WWD_RELOAD_KEY      = 16'h5FA0;
   localparam logic [15:0]      WWD_UNLOCK_KEY      = 16'h35CA;
   localparam logic [15:0]      WWD_LOCK_KEY        = 16'h0000;

   // Mode word fields
   localparam int WWD_MODE_RLD_LSB  = 0;    // 12-bit reload value
   localparam int WWD_MODE_PRE_LSB  = 12;   // 3-bit prescaler select
   localparam int WWD_MODE_EN_BIT   = 16;   // watchdog enable
   localparam int WWD_MODE_RST_BIT  = 17;   // reset request enable
   localparam int WWD_MODE_DBG_BIT  = 18;   // freeze in debug halt
   localparam int WWD_MODE_SRC_BIT  = 19;   // 0 internal, 1 external osc

   // Status word fields
   localparam int WWD_STAT_UNDER_BIT = 0;
   localparam int WWD_STAT_EARLY_BIT = 1;
   localparam int WWD_STAT_LOCK_BIT  = 2;
   localparam int WWD_STAT_CNT_LSB   = 16;

   // Reset values
   localparam logic [11:0] WWD_RLD_RST   = 12'hFFF;
   localparam logic [11:0] WWD_DELTA_RST = 12'hFFF;
   localparam logic [2:0]  WWD_PRE_RST   = 3'h0;

   // Configuration carried as one struct
   typedef struct packed {
      logic        src_ext;
      logic        dbg_freeze;
      logic        rst_en;
      logic        enable;
      logic [2:0]  prescale;
      logic [11:0] reload;
   } wwd_cfg_type;

   // Count state
   typedef enum logic [0:0] {
      WWD_ST_IDLE = 1'b0,
      WWD_ST_RUN  = 1'b1
   } wwd_state_type;

endpackage

// File: src/wwd_watchdog_unit.sv
// Windowed watchdog core with Avalon-MM register slave
//
// Notes on behaviour
// R1 - Twelve-bit counter counts down per tick
// R2 - Three-bit field selects the prescaler division
// R3 - Underflow without reload requests system reset
// R4 - Reload above delta requests reset instead
// R5 - Optionally freeze counting during debug halt
// R6 - Write protection blocks configuration writes
// R7 - Tick source is internal or external oscillator
// R8 - Accepted reload loads value, restarts next tick
`timescale 1ns/1ps
`default_nettype none

module wwd_watchdog_unit
   import wwd_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Oscillator ticks from pins (asynchronous levels)
   input  wire logic        low_speed_internal_osc,
   input  wire logic        low_speed_external_osc,
   // Processor debug halt (asynchronous level)
   input  wire logic        cpu_debug_halt,
   // System reset request
   output logic             sys_reset_req
);

   // Register state
   wwd_cfg_type   cfg_ff;
   logic [11:0]   delta_ff;
   logic          lock_ff;
   logic [11:0]   count_ff;
   logic [6:0]    prediv_ff;
   logic          under_ff;
   logic          early_ff;
   logic          rstreq_ff;
   logic          rd_done_ff;
   logic [31:0]   rdata_ff;
   wwd_state_type state_ff;
   logic [2:0]    osc_i_sync_ff;
   logic [2:0]    osc_e_sync_ff;
   logic [2:0]    dbg_sync_ff;
   logic          osc_i_ff;
   logic          osc_e_ff;
   logic          dbg_ff;
   logic          osc_prev_ff;

   // Tick divider: 2^prescale source cycles per tick, up to 128;
   // the compare is one bit wider than the count so 2^7 still fits before the subtract
   function automatic logic pre_hit(input logic [6:0] cnt, input logic [2:0] sel);
      logic [7:0] full;
      full    = (8'h01 << sel) - 8'h01;
      pre_hit = ({1'b0, cnt} >= full);
   endfunction

   // Register select by word offset
   function automatic logic ofs_hit(input logic [3:0] addr, input logic [3:0] ofs);
      ofs_hit = (addr == ofs);
   endfunction

   // Control key match in the upper half of the written word
   function automatic logic key_hit(input logic [31:0] wdata, input logic [15:0] key);
      key_hit = (wdata[31:16] == key);
   endfunction

   // Pin filter: new level only once stages two and three agree,
   // otherwise hold, so a level caught mid-change never counts twice
   function automatic logic pin_filter(input logic [2:0] stages, input logic held);
      pin_filter = (stages[1] == stages[2]) ? stages[2] : held;
   endfunction

   // Sticky flag: an event in the same cycle as a clear keeps the flag set
   function automatic logic sticky_next(input logic set, input logic clr, input logic cur);
      sticky_next = set | (cur & ~clr);
   endfunction

   // Mode word to configuration, field by field;
   // bit 15 is spare, so a plain 20-bit copy would shift every upper field
   function automatic wwd_cfg_type mode_unpack(input logic [31:0] w);
      wwd_cfg_type c;
      c.src_ext    = w[WWD_MODE_SRC_BIT];
      c.dbg_freeze = w[WWD_MODE_DBG_BIT];
      c.rst_en     = w[WWD_MODE_RST_BIT];
      c.enable     = w[WWD_MODE_EN_BIT];
      c.prescale   = w[WWD_MODE_PRE_LSB +: 3];
      c.reload     = w[WWD_MODE_RLD_LSB +: 12];
      mode_unpack  = c;
   endfunction

   // Configuration back to the mode word; spare bits read as zero
   function automatic logic [31:0] mode_pack(input wwd_cfg_type c);
      logic [31:0] w;
      w                         = 32'h0000_0000;
      w[WWD_MODE_SRC_BIT]       = c.src_ext;
      w[WWD_MODE_DBG_BIT]       = c.dbg_freeze;
      w[WWD_MODE_RST_BIT]       = c.rst_en;
      w[WWD_MODE_EN_BIT]        = c.enable;
      w[WWD_MODE_PRE_LSB +: 3]  = c.prescale;
      w[WWD_MODE_RLD_LSB +: 12] = c.reload;
      mode_pack                 = w;
   endfunction

   // Bus decode
   wire         sel_ctrl   = ofs_hit(avs_address, WWD_CTRL_OFS);
   wire         sel_mode   = ofs_hit(avs_address, WWD_MODE_OFS);
   wire         sel_delta  = ofs_hit(avs_address, WWD_DELTA_OFS);
   wire         sel_status = ofs_hit(avs_address, WWD_STATUS_OFS);
   wire         wr_full    = avs_write & (&avs_byteenable);
   wire         key_reload = wr_full & sel_ctrl & key_hit(avs_writedata, WWD_RELOAD_KEY)
                             & avs_writedata[WWD_CTRL_RELOAD_BIT];
   wire         key_unlock = wr_full & sel_ctrl & key_hit(avs_writedata, WWD_UNLOCK_KEY);
   wire         key_lock   = wr_full & sel_ctrl & key_hit(avs_writedata, WWD_LOCK_KEY);
   // R6 protected config writes
   wire         cfg_wr_ok  = wr_full & ~lock_ff;

   // Writes take effect at once; reads wait one cycle for registered data
   wire         rd_first   = avs_read & ~rd_done_ff;
   assign avs_waitrequest = rd_first;
   assign avs_readdata    = rdata_ff;
   assign sys_reset_req   = rstreq_ff;

   // Pin synchronisers: three stages, change taken when stages two and three agree
   // Each source level must last two core cycles or more, else edges are lost
   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_i_sync_ff <= 3'h0;
         osc_e_sync_ff <= 3'h0;
         dbg_sync_ff   <= 3'h0;
      end else begin
         osc_i_sync_ff <= {osc_i_sync_ff[1:0], low_speed_internal_osc};
         osc_e_sync_ff <= {osc_e_sync_ff[1:0], low_speed_external_osc};
         dbg_sync_ff   <= {dbg_sync_ff[1:0], cpu_debug_halt};
      end
   end

   wire nxt_osc_i = pin_filter(osc_i_sync_ff, osc_i_ff);
   wire nxt_osc_e = pin_filter(osc_e_sync_ff, osc_e_ff);
   wire nxt_dbg   = pin_filter(dbg_sync_ff, dbg_ff);

   // Filtered pin levels
   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_i_ff <= 1'b0;
         osc_e_ff <= 1'b0;
         dbg_ff   <= 1'b0;
      end else begin
         osc_i_ff <= nxt_osc_i;
         osc_e_ff <= nxt_osc_e;
         dbg_ff   <= nxt_dbg;
      end
   end

   // R7 source select, rising edge is one source cycle
   wire osc_sel  = cfg_ff.src_ext ? osc_e_ff : osc_i_ff;
   wire osc_rise = osc_sel & ~osc_prev_ff;
   // R5 debug freeze
   wire frozen   = cfg_ff.dbg_freeze & dbg_ff;
   wire running  = (state_ff == WWD_ST_RUN);
   wire src_step = running & osc_rise & ~frozen;
   // R2 prescaled tick
   wire tick     = src_step & pre_hit(prediv_ff, cfg_ff.prescale);
   // Reload while idle is never early: the window opens once counting
   // R4 reload outside the window
   wire early    = key_reload & running & (count_ff > delta_ff);
   wire good_rld = key_reload & ~early;
   // R3 underflow on tick at zero
   wire underflow = tick & (count_ff == 12'h000);

   // Previous selected source level
   always_ff @(posedge core_clk) begin
      if (reset) begin
         osc_prev_ff <= 1'b0;
      end else begin
         osc_prev_ff <= osc_sel;
      end
   end

   // Run state follows the enable bit
   // Leaving RUN parks the count at reload, so a restart is a full period
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_ff <= WWD_ST_IDLE;
      end else begin
         unique case (state_ff)
            WWD_ST_IDLE: begin
               if (cfg_ff.enable) begin
                  state_ff <= WWD_ST_RUN;
               end
            end
            WWD_ST_RUN: begin
               if (!cfg_ff.enable) begin
                  state_ff <= WWD_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Prescaler: cleared by reload so the next full tick restarts counting;
   // seven bits cover the largest division of 128 source cycles
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prediv_ff <= 7'h00;
      end else if (good_rld || tick || !running) begin
         prediv_ff <= 7'h00;
      end else if (src_step) begin
         prediv_ff <= prediv_ff + 7'h01;
      end
   end

   // Down counter
   // Underflow reloads at once, so the next period starts without a gap
   always_ff @(posedge core_clk) begin
      if (reset) begin
         count_ff <= WWD_RLD_RST;
      end else if (good_rld || !running || underflow) begin
         // R8 load reload value
         count_ff <= cfg_ff.reload;
      end else if (tick) begin
         // R1 count down
         count_ff <= count_ff - 12'h001;
      end
   end

   // Sticky causes; set wins over clear, cleared by writing one.
   // A locked unit refuses the clear too, so the cause survives for software
   wire clr_under  = cfg_wr_ok & sel_status & avs_writedata[WWD_STAT_UNDER_BIT];
   wire clr_early  = cfg_wr_ok & sel_status & avs_writedata[WWD_STAT_EARLY_BIT];
   wire nxt_under  = sticky_next(underflow, clr_under, under_ff);
   wire nxt_early  = sticky_next(early, clr_early, early_ff);
   // R3 R4 reset request when enabled
   wire nxt_rstreq = cfg_ff.rst_en & (underflow | early);

   // Cause flags and a one-cycle reset request pulse
   always_ff @(posedge core_clk) begin
      if (reset) begin
         under_ff  <= 1'b0;
         early_ff  <= 1'b0;
         rstreq_ff <= 1'b0;
      end else begin
         under_ff  <= nxt_under;
         early_ff  <= nxt_early;
         rstreq_ff <= nxt_rstreq;
      end
   end

   // Configuration registers and protect lock
   // Lock and unlock keys pass while locked, or a lock could never be lifted
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_ff   <= '{src_ext: 1'b0, dbg_freeze: 1'b0, rst_en: 1'b0, enable: 1'b0,
                       prescale: WWD_PRE_RST, reload: WWD_RLD_RST};
         delta_ff <= WWD_DELTA_RST;
         lock_ff  <= 1'b0;
      end else begin
         if (key_unlock) begin
            lock_ff <= 1'b0;
         end else if (key_lock) begin
            lock_ff <= 1'b1;
         end
         // R6 ignore when locked
         if (cfg_wr_ok && sel_mode) begin
            cfg_ff <= mode_unpack(avs_writedata);
         end
         if (cfg_wr_ok && sel_delta) begin
            delta_ff <= avs_writedata[11:0];
         end
      end
   end

   // Read mux; control and unmapped offsets read zero
   wire [31:0] mode_word   = mode_pack(cfg_ff);
   wire [31:0] status_word = {4'h0, count_ff, 13'h0000, lock_ff, early_ff, under_ff};
   wire [31:0] rd_mux      = sel_mode   ? mode_word :
                             sel_delta  ? {20'h0_0000, delta_ff} :
                             sel_status ? status_word : 32'h0000_0000;

   // Read data registered; one wait cycle per read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_done_ff <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         rd_done_ff <= rd_first;
         // Captured only in the wait cycle, so data stands until the next read
         if (rd_first) begin
            rdata_ff <= rd_mux;
         end
      end
   end

endmodule

`default_nettype wire

// File: verification/tb_wwd_watchdog_unit.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_wwd_watchdog_unit;
   import wwd_pkg::*;
   logic        core_clk, reset, avs_read, avs_write, int_osc, ext_osc, halt;
   logic        avs_waitrequest, sys_reset_req;
   logic [3:0]  avs_address, avs_byteenable;
   logic [11:0] r;
   logic [31:0] avs_writedata, avs_readdata, seed, q[$];
   int          err_count, cmp_count, pulses;
   wwd_watchdog_unit u_dut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .low_speed_internal_osc(int_osc), .low_speed_external_osc(ext_osc), .cpu_debug_halt(halt),
      .sys_reset_req(sys_reset_req));
   always #50 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for waitrequest low at a rising edge
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         err_count++;
         $display("ERROR %0t: bus timeout", $time);
         stop_test();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      q.push_back(e);
      avs_address <= a;
      avs_read    <= 1'b1;
      wait_ack();
      avs_read <= 1'b0;
   endtask
   // Return to idle first so the count restarts from reload
   task automatic cfg(input logic [31:0] m);
      wr(WWD_MODE_OFS, 32'h0);
      wr(WWD_MODE_OFS, m);
   endtask
   // Slow oscillator pulses, then time for the synchroniser
   task automatic osc(input int n, input logic ext);
      repeat (n) begin
         {ext_osc, int_osc} <= ext ? 2'b10 : 2'b01;
         repeat (3) @(posedge core_clk);
         {ext_osc, int_osc} <= 2'b00;
         repeat (3) @(posedge core_clk);
      end
      repeat (8) @(posedge core_clk);
   endtask
   // Read monitor takes the oldest expectation
   always @(posedge core_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         chk(avs_readdata, q.size() > 0 ? q.pop_front() : 32'hx);
      if (sys_reset_req === 1'b1)
         pulses++;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      $display("ERROR %0t: run timeout", $time);
      stop_test();
   end
   initial begin
      {core_clk, avs_read, avs_write, int_osc, ext_osc, halt} = 6'h00;
      {avs_address, avs_writedata, avs_byteenable} = {36'h0, 4'hF};
      {reset, err_count, cmp_count, pulses, seed} = {1'b1, 96'h0, 32'hc54a_b2b6};
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      rd(WWD_MODE_OFS, 32'h0000_0FFF);
      rd(WWD_DELTA_OFS, 32'h0000_0FFF);
      rd(WWD_STATUS_OFS, 32'h0FFF_0000);
      rd(WWD_CTRL_OFS, 32'h0000_0000);
      rd(4'h2, 32'h0000_0000);
      $display("test reset values done");
      for (int p = 0; p < 3; p++) begin
         seed = lfsr(seed);
         r = {4'h1, seed[7:0]} - 12'(4 >> p);
         cfg({12'h000, 4'h1, 1'b0, 3'(p), 4'h1, seed[7:0]});
         osc(4, 1'b0);
         rd(WWD_STATUS_OFS, {4'h0, r, 16'h0000});
      end
      // Largest division; spare mode bit 15 written as one, reads back zero
      seed = lfsr(seed);
      r = {4'h1, seed[7:0]} - 12'h001;
      cfg({16'h0001, 4'hF, 4'h1, seed[7:0]});
      rd(WWD_MODE_OFS, {16'h0001, 4'h7, 4'h1, seed[7:0]});
      osc(127, 1'b0);
      rd(WWD_STATUS_OFS, {8'h01, seed[7:0], 16'h0000});
      osc(1, 1'b0);
      rd(WWD_STATUS_OFS, {4'h0, r, 16'h0000});
      $display("test countdown done");
      cfg(32'h0003_0003);
      pulses = 0;
      osc(4, 1'b0);
      chk(32'(pulses), 32'h1);
      rd(WWD_STATUS_OFS, 32'h0003_0001);
      wr(WWD_STATUS_OFS, 32'h0000_0003);
      wr(WWD_DELTA_OFS, 32'h0000_0001);
      wr(WWD_CTRL_OFS, {WWD_RELOAD_KEY, 16'h0001});
      rd(WWD_STATUS_OFS, 32'h0003_0002);
      osc(2, 1'b0);
      wr(WWD_CTRL_OFS, {WWD_RELOAD_KEY, 16'h0001});
      rd(WWD_STATUS_OFS, 32'h0003_0002);
      chk(32'(pulses), 32'h2);
      wr(WWD_STATUS_OFS, 32'h0000_0003);
      $display("test window done");
      cfg(32'h0005_0003);
      halt <= 1'b1;
      repeat (8) @(posedge core_clk);
      osc(2, 1'b0);
      rd(WWD_STATUS_OFS, 32'h0003_0000);
      halt <= 1'b0;
      repeat (8) @(posedge core_clk);
      osc(1, 1'b0);
      rd(WWD_STATUS_OFS, 32'h0002_0000);
      cfg(32'h0009_0003);
      osc(2, 1'b0);
      osc(1, 1'b1);
      rd(WWD_STATUS_OFS, 32'h0002_0000);
      $display("test freeze and source done");
      wr(WWD_CTRL_OFS, {WWD_LOCK_KEY, 16'h0000});
      seed = lfsr(seed);
      wr(WWD_MODE_OFS, seed);
      wr(WWD_DELTA_OFS, seed);
      rd(WWD_STATUS_OFS, 32'h0002_0004);
      rd(WWD_MODE_OFS, 32'h0009_0003);
      rd(WWD_DELTA_OFS, 32'h0000_0001);
      wr(WWD_CTRL_OFS, {WWD_UNLOCK_KEY, 16'h0000});
      avs_byteenable <= 4'h7;
      wr(WWD_DELTA_OFS, 32'h0000_0002);
      avs_byteenable <= 4'hF;
      rd(WWD_DELTA_OFS, 32'h0000_0001);
      rd(WWD_STATUS_OFS, 32'h0002_0000);
      $display("test protection done");
      stop_test();
   end
endmodule
`default_nettype wire

// File: verification/wwd_checker.sv
// Port-level assertions for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module wwd_checker (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Reset request
   input wire logic        sys_reset_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Read phases: first cycle waits, second answers
   sequence s_rd_wait;
      avs_read && avs_waitrequest;
   endsequence
   sequence s_rd_done;
      avs_read && !avs_waitrequest;
   endsequence
   a_write_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
   a_wait_read: assert property (avs_waitrequest |-> avs_read) else $error("wait without read");
   a_read_onewait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest) else $error("read not held");
   a_read_answer: assert property (s_rd_wait ##1 avs_read |-> !avs_waitrequest) else $error("read too slow");
   a_ctrl_zero: assert property (s_rd_done ##0 avs_address == 4'h0 |-> avs_readdata == 32'h0) else $error("ctrl read");
   a_unmapped_zero: assert property (s_rd_done ##0 avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
      else $error("unmapped read");
   a_status_layout: assert property (s_rd_done ##0 avs_address == 4'hC |-> avs_readdata[31:28] == 4'h0
      && avs_readdata[15:3] == 13'h0) else $error("status spare bits");
   a_mode_layout: assert property (s_rd_done ##0 avs_address == 4'h4 |-> avs_readdata[31:20] == 12'h0
      && avs_readdata[15] == 1'b0)
      else $error("mode spare bits");
   a_pulse_single: assert property (sys_reset_req |=> !sys_reset_req [*3]) else $error("long reset pulse");
   a_reset_quiet: assert property ($fell(reset) |-> !sys_reset_req && avs_readdata == 32'h0) else $error("reset state");
   a_data_hold: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata)) else $error("readdata moved");
endmodule
bind wwd_watchdog_unit wwd_checker u_chk (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .sys_reset_req(sys_reset_req));
`default_nettype wire
